// File: brl_consts.svh
// Operation
// - Host route sends blit result data to aperture reads; line drawing still writes memory with route set
// - Only low two host address bits decoded
// - Rotate source bytes onto destination alignment, packed
// - Sync enable holds ready until data exists
// - Zero-wait enable answers reads without wait states
// - Line steps pixels, depth plus one bytes per pixel
// - Direction bits: line, variant, axis, ydir, xdir
// - Destination address write starts the operation
// - Line stops at whichever of two counts runs out first
// - Error term starts at major delta unless loaded
// - Map address anchors to block starting corner
// - Four-by-one wrap repeats four bytes as colour, three bytes for three-byte pixels
// - Mix bit picks foreground or background operation
// - One mix bit expands to one byte
// - Mix LSB first rising X, MSB first falling
// - Idle aperture read with neither sync nor zero-wait latches read fault
`ifndef BRL_CONSTS_SVH
`define BRL_CONSTS_SVH
// register offsets
`define BRL_A_CTRL   8'h00
`define BRL_A_DEPTH  8'h04
`define BRL_A_DIR    8'h08
`define BRL_A_XCNT   8'h0C
`define BRL_A_YCNT   8'h10
`define BRL_A_DMAJ   8'h14
`define BRL_A_DMIN   8'h18
`define BRL_A_ERR    8'h1C
`define BRL_A_SRC    8'h20
`define BRL_A_DST    8'h24
`define BRL_A_STAT   8'h28
`define BRL_A_PAT    8'h2C
`define BRL_A_MIX    8'h30
`define BRL_A_ROP    8'h34
`define BRL_A_PITCH  8'h38
// control bits
`define BRL_CTRL_ROUTE 0
`define BRL_CTRL_SYNC  1
`define BRL_CTRL_ZWS   2
// direction bits
`define BRL_DIR_XDIR 0
`define BRL_DIR_YDIR 1
`define BRL_DIR_AXIS 2
`define BRL_DIR_ALG  4
`define BRL_DIR_LOAD_ERROR_TERM_SELECT 5
`define BRL_DIR_LINE 7
// status bits
`define BRL_STAT_RFLT 0
`define BRL_STAT_DVAL 1
`define BRL_STAT_ACT  7
// misc values
`define BRL_DEPTH3    2'h2
`define BRL_WORD_STEP 32'h4
`define BRL_BE_ALL    4'hF
`define BRL_BE_ONE    4'h1
`endif

// File: brl_pkg.sv
package brl_pkg;
  typedef enum logic [2:0] {BRL_IDLE, BRL_PRE, BRL_WSRC, BRL_OUT, BRL_LINE} brl_fsm_t;

  // display memory request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } brl_mem_t;

  // aperture answer
  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
  } brl_hrsp_t;

  // software registers
  typedef struct packed {
    logic        route;
    logic        sync;
    logic        zws;
    logic [1:0]  depth;
    logic [7:0]  dir;
    logic [11:0] xcnt;
    logic [11:0] ycnt;
    logic [11:0] dmaj;
    logic [11:0] dmin;
    logic [15:0] err;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] pat;
    logic [31:0] mix;
    logic [7:0]  fg;
    logic [7:0]  bg;
    logic [15:0] pitch;
  } brl_regs_t;

  // whole block state
  typedef struct packed {
    brl_regs_t   r;
    brl_fsm_t    fsm;
    brl_mem_t    mem;
    brl_hrsp_t   hrsp;
    logic [31:0] rdata;
    logic        active;
    logic        rflt;
    logic        dval;
    logic [31:0] dword;
    logic [31:0] prev;
    logic        hpend;
    logic [1:0]  hlane;
    logic [11:0] cnt;
    logic [11:0] lx;
    logic [11:0] ly;
    logic [15:0] e;
    logic [31:0] addr;
    logic [31:0] daddr;
    logic [1:0]  bidx;
    logic [4:0]  mixi;
    logic [1:0]  patb;
  } brl_st_t;
endpackage

// File: brl_rop_lane.sv
`timescale 1ns/100ps
`default_nettype none
module brl_rop_lane (
  // operands
  input  wire logic [7:0] src,
  input  wire logic [7:0] pat,
  input  wire logic       mix,
  // operation codes
  input  wire logic [7:0] fg_rop,
  input  wire logic [7:0] bg_rop,
  // result
  output logic      [7:0] res
);
  logic [7:0] rop;

  // per bit table lookup, destination is not fetched here and reads as zero
  always_comb
  begin
    rop = mix ? fg_rop : bg_rop;
    for (int i = 0; i < 8; i++)
    begin
      res[i] = rop[{pat[i], src[i], 1'b0}];
    end
  end
endmodule
`default_nettype wire

// File: brl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "brl_consts.svh"
module brl_top (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // host aperture
  input  wire logic              host_rd,
  input  wire logic [1:0]        host_addr,
  output var brl_pkg::brl_hrsp_t host_rsp,
  // display memory
  output var brl_pkg::brl_mem_t  mem_req,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_rvalid
);
  brl_pkg::brl_st_t    s_ff;
  brl_pkg::brl_st_t    nxt_s;
  logic                rs1_ff;
  logic                rs2_ff;
  logic                three;
  logic                line;
  logic [1:0]          rsh;
  logic [63:0]         cat;
  logic [1:0]          pidx;
  logic [4:0]          mi;
  logic [3:0][7:0]     l_src;
  logic [3:0][7:0]     l_pat;
  logic [3:0][7:0]     l_out;
  logic [3:0]          l_mix;
  logic                serve;
  logic [31:0]         rv;
  logic [31:0]         boff;
  logic [31:0]         baddr;
  logic [15:0]         e2;
  logic                minor;
  logic                xmv;
  logic                ymv;
  logic [11:0]         bpp;
  logic [31:0]         xo;
  logic [31:0]         yo;

  // wrapped byte index, modulo three for three byte pixels
  function automatic logic [1:0] brl_wrap(input logic [1:0] b, input logic [2:0] k, input logic thr);
    logic [2:0] t;
    t = {1'b0, b} + k;
    if (thr && t >= 3'h3)
      t = t - 3'h3;
    if (thr && t >= 3'h3)
      t = t - 3'h3;
    return t[1:0];
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end
    else
    begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end

  // lane operand feed for the four byte lanes
  always_comb
  begin
    three = (s_ff.r.depth == `BRL_DEPTH3);
    line  = (s_ff.fsm == brl_pkg::BRL_LINE);
    rsh   = s_ff.r.src[1:0] - s_ff.r.dst[1:0];
    cat   = {mem_rdata, s_ff.prev} >> {rsh, 3'b000};
    pidx  = 2'h0;
    mi    = 5'h0;
    for (int k = 0; k < 4; k++)
    begin
      pidx     = brl_wrap(s_ff.patb, 3'(k), three);
      l_pat[k] = s_ff.r.pat[{pidx, 3'b000} +: 8];
      l_src[k] = line ? l_pat[k] : cat[8 * k +: 8];
      mi       = s_ff.mixi + 5'(k);
      if (line)
        l_mix[k] = 1'b1;
      else if (s_ff.r.dir[`BRL_DIR_XDIR])
        l_mix[k] = s_ff.r.mix[~mi];
      else
        l_mix[k] = s_ff.r.mix[mi];
    end
  end

  // one raster operation per byte lane
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
      brl_rop_lane u_lane (
        .src    (l_src[g]),
        .pat    (l_pat[g]),
        .mix    (l_mix[g]),
        .fg_rop (s_ff.r.fg),
        .bg_rop (s_ff.r.bg),
        .res    (l_out[g])
      );
    end
  endgenerate

  // next state of the whole block
  always_comb
  begin
    nxt_s          = s_ff;
    nxt_s.mem.rd   = 1'b0;
    nxt_s.mem.wr   = 1'b0;
    nxt_s.hrsp.ready = 1'b0;
    nxt_s.rdata    = 32'h0;
    serve = 1'b0;
    rv    = 32'h0;
    boff  = 32'h0;
    baddr = 32'h0;
    e2    = 16'h0;
    minor = 1'b0;
    xmv   = 1'b0;
    ymv   = 1'b0;
    bpp   = 12'({10'h0, s_ff.r.depth}) + 12'h1;
    xo    = 32'h0;
    yo    = 32'h0;

    // register read, data valid in the following cycle only
    if (reg_rd)
    begin
      unique case (reg_addr)
        `BRL_A_CTRL:
        begin
          rv[`BRL_CTRL_ROUTE] = s_ff.r.route;
          rv[`BRL_CTRL_SYNC]  = s_ff.r.sync;
          rv[`BRL_CTRL_ZWS]   = s_ff.r.zws;
        end
        `BRL_A_DEPTH: rv = {30'h0, s_ff.r.depth};
        `BRL_A_DIR:   rv = {24'h0, s_ff.r.dir};
        `BRL_A_XCNT:  rv = {20'h0, s_ff.r.xcnt};
        `BRL_A_YCNT:  rv = {20'h0, s_ff.r.ycnt};
        `BRL_A_DMAJ:  rv = {20'h0, s_ff.r.dmaj};
        `BRL_A_DMIN:  rv = {20'h0, s_ff.r.dmin};
        `BRL_A_ERR:   rv = {16'h0, s_ff.r.err};
        `BRL_A_SRC:   rv = s_ff.r.src;
        `BRL_A_DST:   rv = s_ff.r.dst;
        `BRL_A_STAT:
        begin
          rv[`BRL_STAT_RFLT] = s_ff.rflt;
          rv[`BRL_STAT_DVAL] = s_ff.dval;
          rv[`BRL_STAT_ACT]  = s_ff.active;
        end
        `BRL_A_PAT:   rv = s_ff.r.pat;
        `BRL_A_MIX:   rv = s_ff.r.mix;
        `BRL_A_ROP:   rv = {16'h0, s_ff.r.bg, s_ff.r.fg};
        `BRL_A_PITCH: rv = {16'h0, s_ff.r.pitch};
        default:      rv = 32'h0;
      endcase
      nxt_s.rdata = rv;
    end

    // register write
    if (reg_wr)
    begin
      unique case (reg_addr)
        `BRL_A_CTRL:
        begin
          nxt_s.r.route = reg_wdata[`BRL_CTRL_ROUTE];
          nxt_s.r.sync  = reg_wdata[`BRL_CTRL_SYNC];
          nxt_s.r.zws   = reg_wdata[`BRL_CTRL_ZWS];
        end
        `BRL_A_DEPTH: nxt_s.r.depth = reg_wdata[1:0];
        `BRL_A_DIR:   nxt_s.r.dir   = reg_wdata[7:0];
        `BRL_A_XCNT:  nxt_s.r.xcnt  = reg_wdata[11:0];
        `BRL_A_YCNT:  nxt_s.r.ycnt  = reg_wdata[11:0];
        `BRL_A_DMAJ:  nxt_s.r.dmaj  = reg_wdata[11:0];
        `BRL_A_DMIN:  nxt_s.r.dmin  = reg_wdata[11:0];
        `BRL_A_ERR:   nxt_s.r.err   = reg_wdata[15:0];
        `BRL_A_SRC:   nxt_s.r.src   = reg_wdata;
        `BRL_A_DST:   nxt_s.r.dst   = reg_wdata;
        `BRL_A_STAT:
        begin
          if (reg_wdata[`BRL_STAT_RFLT])
            nxt_s.rflt = 1'b0;
        end
        `BRL_A_PAT:   nxt_s.r.pat   = reg_wdata;
        `BRL_A_MIX:   nxt_s.r.mix   = reg_wdata;
        `BRL_A_ROP:
        begin
          nxt_s.r.fg = reg_wdata[7:0];
          nxt_s.r.bg = reg_wdata[15:8];
        end
        `BRL_A_PITCH: nxt_s.r.pitch = reg_wdata[15:0];
        default:      nxt_s.rdata   = nxt_s.rdata;
      endcase
    end

    // aperture read service, one read outstanding; zero wait serves a new read in its own cycle, skipping the sync wait and the read fault
    if (s_ff.hpend || host_rd)
    begin
      if (s_ff.r.zws)
        serve = 1'b1;
      else if (s_ff.r.sync)
        serve = s_ff.dval;
      else
      begin
        serve = 1'b1;
        if (!s_ff.active)
          nxt_s.rflt = 1'b1;
      end
    end
    if (host_rd)
      nxt_s.hlane = host_addr;
    if (serve)
    begin
      nxt_s.hrsp.ready = 1'b1;
      nxt_s.hrsp.rdata = s_ff.dword >> {nxt_s.hlane, 3'b000};
      nxt_s.dval  = 1'b0;
      nxt_s.hpend = 1'b0;
    end
    else if (host_rd)
      nxt_s.hpend = 1'b1;

    // operation sequencer
    unique case (s_ff.fsm)
      brl_pkg::BRL_IDLE:
      begin
        if (reg_wr && reg_addr == `BRL_A_DST)
        begin
          nxt_s.active = 1'b1;
          nxt_s.patb   = 2'h0; // map byte zero sits at the starting corner
          nxt_s.mixi   = 5'h0;
          if (s_ff.r.dir[`BRL_DIR_LINE])
          begin
            nxt_s.fsm  = brl_pkg::BRL_LINE;
            nxt_s.lx   = s_ff.r.xcnt;
            nxt_s.ly   = s_ff.r.ycnt;
            nxt_s.e    = s_ff.r.dir[`BRL_DIR_LOAD_ERROR_TERM_SELECT] ? s_ff.r.err : {4'h0, s_ff.r.dmaj};
            nxt_s.addr = reg_wdata;
            nxt_s.bidx = 2'h0;
          end
          else
          begin
            nxt_s.fsm      = brl_pkg::BRL_PRE;
            nxt_s.cnt      = s_ff.r.xcnt;
            nxt_s.addr     = {s_ff.r.src[31:2], 2'b00};
            nxt_s.daddr    = {reg_wdata[31:2], 2'b00};
            nxt_s.mem.rd   = 1'b1;
            nxt_s.mem.addr = {s_ff.r.src[31:2], 2'b00};
          end
        end
      end
      brl_pkg::BRL_PRE:
      begin
        // first source word primes the rotator
        if (mem_rvalid)
        begin
          nxt_s.prev     = mem_rdata;
          nxt_s.addr     = s_ff.addr + `BRL_WORD_STEP;
          nxt_s.mem.rd   = 1'b1;
          nxt_s.mem.addr = s_ff.addr + `BRL_WORD_STEP;
          nxt_s.fsm      = brl_pkg::BRL_WSRC;
        end
      end
      brl_pkg::BRL_WSRC:
      begin
        // rotate, combine and pack one doubleword
        if (mem_rvalid)
        begin
          nxt_s.dword = l_out;
          nxt_s.dval  = 1'b1;
          nxt_s.prev  = mem_rdata;
          nxt_s.mixi  = s_ff.mixi + 5'h4;
          nxt_s.patb  = brl_wrap(s_ff.patb, 3'h4, three);
          nxt_s.fsm   = brl_pkg::BRL_OUT;
        end
      end
      brl_pkg::BRL_OUT:
      begin
        if (!s_ff.r.route && s_ff.dval)
        begin
          nxt_s.mem.wr    = 1'b1;
          nxt_s.mem.addr  = s_ff.daddr;
          nxt_s.mem.wdata = s_ff.dword;
          nxt_s.mem.be    = `BRL_BE_ALL;
          nxt_s.daddr     = s_ff.daddr + `BRL_WORD_STEP;
          nxt_s.dval      = 1'b0;
        end
        else if (!s_ff.dval)
        begin
          if (s_ff.cnt == 12'h0)
          begin
            nxt_s.fsm    = brl_pkg::BRL_IDLE;
            nxt_s.active = 1'b0;
          end
          else
          begin
            nxt_s.cnt      = s_ff.cnt - 12'h1;
            nxt_s.addr     = s_ff.addr + `BRL_WORD_STEP;
            nxt_s.mem.rd   = 1'b1;
            nxt_s.mem.addr = s_ff.addr + `BRL_WORD_STEP;
            nxt_s.fsm      = brl_pkg::BRL_WSRC;
          end
        end
      end
      brl_pkg::BRL_LINE:
      begin
        // one byte of the current pixel per cycle
        boff  = {30'h0, s_ff.bidx};
        baddr = s_ff.r.dir[`BRL_DIR_XDIR] ? s_ff.addr - boff : s_ff.addr + boff;
        nxt_s.mem.wr    = 1'b1;
        nxt_s.mem.addr  = baddr;
        nxt_s.mem.be    = `BRL_BE_ONE << baddr[1:0];
        nxt_s.mem.wdata = {4{l_out[0]}};
        nxt_s.patb      = brl_wrap(s_ff.patb, 3'h1, three);
        if (s_ff.bidx != s_ff.r.depth)
          nxt_s.bidx = s_ff.bidx + 2'h1;
        else
        begin
          nxt_s.bidx = 2'h0;
          e2 = s_ff.e + {3'h0, s_ff.r.dmin, 1'b0};
          if (s_ff.r.dir[`BRL_DIR_ALG])
            minor = !e2[15] && (e2 != 16'h0);
          else
            minor = !e2[15];
          if (minor)
            e2 = e2 - {3'h0, s_ff.r.dmaj, 1'b0};
          nxt_s.e = e2;
          xmv = !s_ff.r.dir[`BRL_DIR_AXIS] || minor;
          ymv = s_ff.r.dir[`BRL_DIR_AXIS] || minor;
          if ((xmv && s_ff.lx < bpp) || (ymv && s_ff.ly == 12'h0))
          begin
            nxt_s.fsm    = brl_pkg::BRL_IDLE;
            nxt_s.active = 1'b0;
          end
          else
          begin
            if (xmv)
            begin
              nxt_s.lx = s_ff.lx - bpp;
              xo = s_ff.r.dir[`BRL_DIR_XDIR] ? -{20'h0, bpp} : {20'h0, bpp};
            end
            if (ymv)
            begin
              nxt_s.ly = s_ff.ly - 12'h1;
              yo = s_ff.r.dir[`BRL_DIR_YDIR] ? -{16'h0, s_ff.r.pitch} : {16'h0, s_ff.r.pitch};
            end
            nxt_s.addr = s_ff.addr + xo + yo;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rs2_ff)
  begin
    if (!rs2_ff)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // outputs straight from the state register
  assign reg_rdata = s_ff.rdata;
  assign host_rsp  = s_ff.hrsp;
  assign mem_req   = s_ff.mem;
endmodule
`default_nettype wire

// File: brl_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "brl_consts.svh"
module brl_checker (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // register writes
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  // host aperture
  input wire logic               host_rd,
  input wire brl_pkg::brl_hrsp_t host_rsp,
  // display memory
  input wire brl_pkg::brl_mem_t  mem_req,
  input wire logic               mem_rvalid
);
  logic route_q;
  logic sync_q;
  logic zws_q;
  logic line_q;
  logic pend_q;
  logic word_q;

  // shadows of control and direction, pending aperture read, memory read answer seen since the destination write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {route_q, sync_q, zws_q, line_q, pend_q, word_q} <= 6'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `BRL_A_CTRL)
      begin
        {zws_q, sync_q, route_q} <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `BRL_A_DIR)
      begin
        line_q <= reg_wdata[`BRL_DIR_LINE];
      end
      pend_q <= host_rd | (pend_q & ~host_rsp.ready);
      word_q <= mem_rvalid | (word_q & ~(reg_wr && reg_addr == `BRL_A_DST));
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  zws_ready_a: assert property (host_rd && zws_q |=> host_rsp.ready)
    else $error("aperture read not answered at once");
  rsp_cause_a: assert property (host_rsp.ready |-> pend_q)
    else $error("ready without a pending read");
  sync_wait_a: assert property (host_rsp.ready && sync_q && !zws_q |-> word_q)
    else $error("synchronised ready before any result word");
  host_nowr_a: assert property (route_q && !line_q |-> !mem_req.wr)
    else $error("memory written while result goes to host");
  line_onehot_a: assert property (line_q && mem_req.wr |-> $onehot(mem_req.be))
    else $error("line write not a single byte");
  blit_full_a: assert property (!line_q && mem_req.wr |-> mem_req.be == 4'hF)
    else $error("packed result word not written whole");
  src_align_a: assert property (mem_req.rd |-> mem_req.addr[1:0] == 2'h0)
    else $error("source fetch not word aligned");
  line_start_a: assert property (reg_wr && reg_addr == `BRL_A_DST && line_q |-> ##[1:4] mem_req.wr)
    else $error("line did not start after destination write");

  // main scenarios reached
  cover property (host_rsp.ready && sync_q);
  cover property (line_q && mem_req.wr);
  cover property (route_q && mem_req.rd);
endmodule

bind brl_top brl_checker u_brl_checker (
  .clk        (clk),
  .rst_n      (rst_n),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .host_rd    (host_rd),
  .host_rsp   (host_rsp),
  .mem_req    (mem_req),
  .mem_rvalid (mem_rvalid)
);
`default_nettype wire

// File: brl_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module brl_mem_model (
  // clock
  input  wire logic              clk,
  // request side
  input  wire brl_pkg::brl_mem_t mem_req,
  input  wire logic              slow,
  // answer side
  output logic      [31:0]       mem_rdata,
  output logic                   mem_rvalid
);
  logic [31:0] mem [0:63];
  logic [5:0]  idx_q;
  logic [1:0]  cnt_q = 2'h0;

  // each byte starts out holding its own address
  initial
  begin
    for (int i = 0; i < 64; i++)
    begin
      mem[i] = 32'h03020100 + 32'h04040404 * i;
    end
  end

  // reads answer after one or three cycles, read data toggles when not valid
  always @(posedge clk)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (cnt_q != 2'h0)
    begin
      cnt_q <= cnt_q - 2'h1;
    end
    if (cnt_q == 2'h1)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= mem[idx_q];
    end
    if (mem_req.rd)
    begin
      idx_q <= mem_req.addr[7:2];
      cnt_q <= slow ? 2'h3 : 2'h1;
    end
    for (int b = 0; b < 4; b++)
    begin
      if (mem_req.wr && mem_req.be[b])
      begin
        mem[mem_req.addr[7:2]][8*b +: 8] <= mem_req.wdata[8*b +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// File: brl_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "brl_consts.svh"
module brl_top_test;
  logic               clk;
  logic               rst_n;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic               host_rd;
  logic [1:0]         host_addr;
  brl_pkg::brl_hrsp_t host_rsp;
  brl_pkg::brl_mem_t  mem_req;
  logic [31:0]        mem_rdata;
  logic               mem_rvalid;
  logic               slow;
  int                 failures;
  int                 samples_checked;
  int                 n;
  logic [31:0]        v;
  logic [7:0]         la [0:8] = '{8'h80, 8'h91, 8'hA2, 8'hA3, 8'h81, 8'hA4, 8'hC0, 8'hC1, 8'hD2};
  logic [7:0]         ld [0:8] = '{8'hA1, 8'hA1, 8'hA1, 8'hA1, 8'h81, 8'hA4, 8'hA1, 8'hA1, 8'hD2};

  brl_top u_brl_top (
    .clk        (clk),
    .rst_n      (rst_n),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .host_rd    (host_rd),
    .host_addr  (host_addr),
    .host_rsp   (host_rsp),
    .mem_req    (mem_req),
    .mem_rdata  (mem_rdata),
    .mem_rvalid (mem_rvalid)
  );

  brl_mem_model u_brl_mem_model (
    .clk        (clk),
    .mem_req    (mem_req),
    .slow       (slow),
    .mem_rdata  (mem_rdata),
    .mem_rvalid (mem_rvalid)
  );

  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && samples_checked > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one bus cycle: every strobe set once, then the taking edge
  task automatic cyc(input logic w, input logic r, input logic h, input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    host_rd   <= h;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cyc(1'b0, 1'b1, 1'b0, a, 32'h0);
    #1;
    d = reg_rdata;
    cyc(1'b0, 1'b0, 1'b0, a, 32'h0);
  endtask

  // aperture read: address held until ready, n counts cycles to ready
  task automatic hrd(input logic [1:0] a, output logic [31:0] d, output int c);
    host_addr <= a;
    cyc(1'b0, 1'b0, 1'b1, 8'h00, 32'h0);
    host_rd <= 1'b0;
    c = 1;
    #1;
    while (host_rsp.ready !== 1'b1 && c < 100)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    chk({31'h0, host_rsp.ready}, 32'h1);
    d = host_rsp.rdata;
    @(posedge clk);
  endtask

  task automatic idle_wait();
    int k;
    k = 0;
    v = 32'h80;
    while (v[7] === 1'b1 && k < 300)
    begin
      rd(`BRL_A_STAT, v);
      k++;
    end
    chk(v & 32'h80, 32'h0);
  endtask

  task automatic go(input logic [31:0] c, dp, dr, xc, yc, mx);
    wr(`BRL_A_CTRL, c);
    wr(`BRL_A_DEPTH, dp);
    wr(`BRL_A_DIR, dr);
    wr(`BRL_A_XCNT, xc);
    wr(`BRL_A_YCNT, yc);
    wr(`BRL_A_MIX, mx);
  endtask

  // watchdog
  initial
  begin
    #200000;
    failures++;
    final_report();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    host_rd = 1'b0;
    host_addr = 2'h0;
    slow = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`BRL_A_STAT, v);
    chk(v, 32'h0);
    rd(8'h3C, v);
    chk(v, 32'h0);
    hrd(2'h0, v, n);
    rd(`BRL_A_STAT, v);
    chk(v & 32'h1, 32'h1);
    wr(`BRL_A_STAT, 32'h1);
    rd(`BRL_A_STAT, v);
    chk(v & 32'h1, 32'h0);
    wr(`BRL_A_PAT, 32'hD4C3B2A1);
    wr(`BRL_A_ROP, 32'h0000F0CC);
    wr(`BRL_A_PITCH, 32'h10);
    // blit to memory with mixed foreground and background bytes
    go(32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h5);
    wr(`BRL_A_SRC, 32'h13);
    wr(`BRL_A_DST, 32'h40);
    idle_wait();
    chk(u_brl_mem_model.mem[16], 32'hD415B213);
    chk(u_brl_mem_model.mem[17], 32'hD4C3B2A1);
    // three-byte pixels repeat three pattern bytes
    go(32'h0, 32'h2, 32'h0, 32'h1, 32'h0, 32'h0);
    wr(`BRL_A_DST, 32'h50);
    idle_wait();
    chk(u_brl_mem_model.mem[20], 32'hA1C3B2A1);
    chk(u_brl_mem_model.mem[21], 32'hB2A1C3B2);
    // result to host with wait states, slow memory
    slow <= 1'b1;
    go(32'h3, 32'h0, 32'h0, 32'h1, 32'h0, 32'hFFFFFFFF);
    wr(`BRL_A_SRC, 32'h21);
    wr(`BRL_A_DST, 32'h0);
    hrd(2'h0, v, n);
    chk(v, 32'h24232221);
    chk(32'(n > 3), 32'h1);
    hrd(2'h1, v, n);
    chk(v, 32'h00282726);
    idle_wait();
    // zero wait states: answered at once, word picked up later
    go(32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF);
    wr(`BRL_A_SRC, 32'h30);
    wr(`BRL_A_DST, 32'h0);
    hrd(2'h0, v, n);
    chk(n, 1);
    repeat (20) cyc(1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    hrd(2'h0, v, n);
    chk(v, 32'h33323130);
    idle_wait();
    // line with default error term, count limited by X
    slow <= 1'b0;
    wr(`BRL_A_PAT, 32'hA1A1A1A1);
    go(32'h0, 32'h0, 32'h80, 32'h3, 32'hFFF, 32'h0);
    wr(`BRL_A_DMAJ, 32'h3);
    wr(`BRL_A_DMIN, 32'h1);
    wr(`BRL_A_DST, 32'h80);
    idle_wait();
    for (int i = 0; i < 6; i++)
    begin
      chk({24'h0, u_brl_mem_model.mem[la[i][7:2]][8*la[i][1:0] +: 8]}, {24'h0, ld[i]});
    end
    // loaded error term, count limited by Y
    go(32'h0, 32'h0, 32'hA0, 32'h3, 32'h0, 32'h0);
    wr(`BRL_A_ERR, 32'hFFFD);
    wr(`BRL_A_DST, 32'hC0);
    idle_wait();
    for (int i = 6; i < 9; i++)
    begin
      chk({24'h0, u_brl_mem_model.mem[la[i][7:2]][8*la[i][1:0] +: 8]}, {24'h0, ld[i]});
    end
    final_report();
  end
endmodule
`default_nettype wire
